// [common/pleb_pkg.sv]
package pleb_pkg;
	// Register byte addresses
	localparam logic [11:0] PLEB_CONTROL_ADDR  = 12'h000;
	localparam logic [11:0] PLEB_DELAY_ADDR    = 12'h004;
	localparam logic [11:0] PLEB_AUX_ADDR      = 12'h008;
	localparam logic [11:0] PLEB_STATUS_ADDR   = 12'h00C;
	// Control field positions
	localparam int PLEB_HI_RISE_BIT    = 15;
	localparam int PLEB_HI_FALL_BIT    = 14;
	localparam int PLEB_LO_RISE_BIT    = 13;
	localparam int PLEB_LO_FALL_BIT    = 12;
	localparam int PLEB_FAULT_EN_BIT   = 11;
	localparam int PLEB_CLIM_EN_BIT    = 10;
	localparam int PLEB_SEL_HIGH_BIT   = 5;
	localparam int PLEB_SEL_LOW_BIT    = 4;
	localparam int PLEB_HI_HIGH_BIT    = 3;
	localparam int PLEB_HI_LOW_BIT     = 2;
	localparam int PLEB_LO_HIGH_BIT    = 1;
	localparam int PLEB_LO_LOW_BIT     = 0;
	// Writable bits of control; bits 9..6 unimplemented
	localparam logic [15:0] PLEB_CONTROL_MASK  = 16'hFC3F;
	// Reset values, source select width and source count
	localparam logic [15:0] PLEB_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] PLEB_DELAY_RESET   = 16'h0000;
	localparam logic [3:0]  PLEB_SRC_RESET     = 4'h0;
	localparam int          PLEB_SRC_WIDTH     = 4;
	localparam int          PLEB_SRC_COUNT     = 16;
endpackage

// [design/pleb_blanking.sv]
module pleb_blanking
(
	// APB slave
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [11:0]                     paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	// PWM generator side
	input  wire logic                            high_side_pwm_out,
	input  wire logic                            low_side_pwm_out,
	input  wire logic [pleb_pkg::PLEB_SRC_COUNT-1:0] blank_sources,
	input  wire logic                            fault_in,
	input  wire logic                            current_limit_in,
	// Masked results
	output logic                                 fault_out,
	output logic                                 current_limit_out
);
	import pleb_pkg::*;

	// PWM sides watched for edges: index 1 high side, index 0 low side
	localparam int SIDES  = 2;

	// Level sources: index 2 selected signal, 1 high side, 0 low side
	localparam int LEVELS = 3;

	// Software-visible registers
	logic [15:0]               blanking_control_reg;
	logic [15:0]               blank_delay;
	logic [PLEB_SRC_WIDTH-1:0] blank_source_select;

	// Blanking counter
	logic [15:0]               blank_count;
	logic [15:0]               next_count;

	// Edge detection, one bit per side
	logic [SIDES-1:0]          side_now;
	logic [SIDES-1:0]          side_prev;
	logic [SIDES-1:0]          side_rise_en;
	logic [SIDES-1:0]          side_fall_en;
	logic [SIDES-1:0]          side_trigger;

	// Level blanking, one bit per source
	logic [LEVELS-1:0]         level_now;
	logic [LEVELS-1:0]         level_high_en;
	logic [LEVELS-1:0]         level_low_en;
	logic [LEVELS-1:0]         level_hit;

	// Combined blanking state
	logic                      trigger;
	logic                      edge_active;
	logic                      state_active;
	logic                      sel_signal;
	logic                      fault_edge_blank;
	logic                      limit_edge_blank;
	logic                      next_fault;
	logic                      next_limit;

	// Bus phases and read data
	logic                      setup;
	logic                      access;
	logic                      write_access;
	logic [31:0]               next_rdata;

	// Address decode used by the error path; the read mux decodes by its own case
	function automatic logic known_addr
	(
		input logic [11:0] a
	);
		return a == PLEB_CONTROL_ADDR
			|| a == PLEB_DELAY_ADDR
			|| a == PLEB_AUX_ADDR
			|| a == PLEB_STATUS_ADDR;
	endfunction

	// Write strobe for one register, used by every register process
	function automatic logic write_hit
	(
		input logic [11:0] a,
		input logic [11:0] reg_addr,
		input logic        wr
	);
		return wr && a == reg_addr;
	endfunction

	// Edge decode shared by both PWM sides
	function automatic logic edge_hit
	(
		input logic rise_en,
		input logic fall_en,
		input logic now,
		input logic prev
	);
		return (rise_en && now && !prev) || (fall_en && !now && prev);
	endfunction

	// Level decode shared by every state-blanking source
	function automatic logic level_blank
	(
		input logic high_en,
		input logic low_en,
		input logic level
	);
		return (high_en && level) || (low_en && !level);
	endfunction

	// Transfer phases
	assign setup        = psel && !penable;
	assign access       = psel && penable && pready;
	assign write_access = access && pwrite;

	// Zero-wait slave: ready answers in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= setup;
	end

	// Error flag taken at setup so it stands with ready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else if (setup)
			pslverr <= !known_addr(paddr);
	end

	// Control register; unimplemented bits never stored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			blanking_control_reg <= PLEB_CONTROL_RESET;
		else if (write_hit(paddr, PLEB_CONTROL_ADDR, write_access))
			blanking_control_reg <= pwdata[15:0] & PLEB_CONTROL_MASK;
	end

	// Delay register; a new value applies from the next trigger
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			blank_delay <= PLEB_DELAY_RESET;
		else if (write_hit(paddr, PLEB_DELAY_ADDR, write_access))
			blank_delay <= pwdata[15:0];
	end

	// Blanking source select
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			blank_source_select <= PLEB_SRC_RESET;
		else if (write_hit(paddr, PLEB_AUX_ADDR, write_access))
			blank_source_select <= pwdata[PLEB_SRC_WIDTH-1:0];
	end

	// Read mux
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		unique case (paddr)
			PLEB_CONTROL_ADDR: next_rdata[15:0] = blanking_control_reg;
			PLEB_DELAY_ADDR:   next_rdata[15:0] = blank_delay;
			PLEB_AUX_ADDR:     next_rdata[PLEB_SRC_WIDTH-1:0] = blank_source_select;
			PLEB_STATUS_ADDR:  next_rdata[2:0] = {sel_signal, state_active, edge_active};
			default:           next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data taken at setup so it is stable in access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup)
			prdata <= pwrite ? 32'h0000_0000 : next_rdata;
	end

	// Side levels and their edge enables
	assign side_now     = {high_side_pwm_out, low_side_pwm_out};
	assign side_rise_en =
	{
		blanking_control_reg[PLEB_HI_RISE_BIT],
		blanking_control_reg[PLEB_LO_RISE_BIT]
	};
	assign side_fall_en =
	{
		blanking_control_reg[PLEB_HI_FALL_BIT],
		blanking_control_reg[PLEB_LO_FALL_BIT]
	};

	// One edge detector per side
	for (genvar s = 0; s < SIDES; s++)
	begin : g_side
		// Previous level; a pin already high at reset release reads as a rise
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				side_prev[s] <= 1'b0;
			else
				side_prev[s] <= side_now[s];
		end

		// Enabled edge on this side
		assign side_trigger[s] = edge_hit(side_rise_en[s], side_fall_en[s], side_now[s], side_prev[s]);
	end

	// Any enabled edge restarts the interval
	assign trigger = |side_trigger;

	// Counter next value; reload wins over the count-down
	always_comb
	begin
		next_count = blank_count;
		if (trigger)
			next_count = blank_delay;
		else if (blank_count != 16'h0000)
			next_count = blank_count - 16'h0001;
	end

	// Blanking counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			blank_count <= 16'h0000;
		else
			blank_count <= next_count;
	end

	// Edge blanking also covers the trigger cycle, so a spike on the edge is caught
	assign edge_active = trigger || blank_count != 16'h0000;

	// Selected blanking signal from the auxiliary select field
	assign sel_signal = blank_sources[blank_source_select];

	// Level sources and their high and low enables
	assign level_now     = {sel_signal, high_side_pwm_out, low_side_pwm_out};
	assign level_high_en =
	{
		blanking_control_reg[PLEB_SEL_HIGH_BIT],
		blanking_control_reg[PLEB_HI_HIGH_BIT],
		blanking_control_reg[PLEB_LO_HIGH_BIT]
	};
	assign level_low_en  =
	{
		blanking_control_reg[PLEB_SEL_LOW_BIT],
		blanking_control_reg[PLEB_HI_LOW_BIT],
		blanking_control_reg[PLEB_LO_LOW_BIT]
	};

	// One level decoder per source
	for (genvar l = 0; l < LEVELS; l++)
	begin : g_level
		assign level_hit[l] = level_blank(level_high_en[l], level_low_en[l], level_now[l]);
	end

	// State blanking conditions ORed together
	assign state_active = |level_hit;

	// Edge blanking applies only where software enabled it per input
	assign fault_edge_blank = blanking_control_reg[PLEB_FAULT_EN_BIT] && edge_active;
	assign limit_edge_blank = blanking_control_reg[PLEB_CLIM_EN_BIT] && edge_active;

	// Masked input values before the output flops
	assign next_fault = fault_in && !state_active && !fault_edge_blank;
	assign next_limit = current_limit_in && !state_active && !limit_edge_blank;

	// Masked fault output; one cycle of latency keeps it glitch-free
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fault_out <= 1'b0;
		else
			fault_out <= next_fault;
	end

	// Masked current-limit output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			current_limit_out <= 1'b0;
		else
			current_limit_out <= next_limit;
	end

	// Limitation: a delay written while the counter runs
	// takes effect only at the next enabled edge, so a running
	// interval is never cut short or stretched by software

	// Limitation: state blanking follows the inputs of this cycle,
	// so it releases one cycle after the blanking level ends,
	// matching the one-cycle latency of the masked outputs
endmodule

// [sim/pleb_blanking_props.sv]
module pleb_blanking_props
	import pleb_pkg::*;
(
	// Watched ports
	input wire logic                      pclk, presetn, psel, penable, pwrite,
	input wire logic [11:0]               paddr,
	input wire logic [31:0]               pwdata, prdata,
	input wire logic                      pready, pslverr, high_side_pwm_out, low_side_pwm_out,
	input wire logic [PLEB_SRC_COUNT-1:0] blank_sources,
	input wire logic                      fault_in, current_limit_in, fault_out, current_limit_out
);
	logic [15:0] ctl;
	logic [3:0]  sel;
	wire         wr  = psel && penable && pready && pwrite;
	wire         blk = blank_sources[sel];
	// Shadow copies, so antecedents follow what software set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl <= '0;
			sel <= '0;
		end
		else if (wr && paddr == PLEB_CONTROL_ADDR)
			ctl <= pwdata[15:0] & PLEB_CONTROL_MASK;
		else if (wr && paddr == PLEB_AUX_ADDR)
			sel <= pwdata[3:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	a_ready_access: assert property (s_setup |=> pready) else $error("no ready");
	a_err_unmapped: assert property (psel && penable && pready && paddr > 12'h00C |-> pslverr) else $error("no err");
	a_pass_clear: assert property (ctl == 16'h0000 |=> fault_out == $past(fault_in)) else $error("pass");
	a_hh_blank: assert property (ctl[3] && high_side_pwm_out |=> !fault_out && !current_limit_out) else $error("hh");
	a_ll_blank: assert property (ctl[0] && !low_side_pwm_out |=> !fault_out) else $error("ll");
	a_sh_blank: assert property (ctl[5] && blk |=> !current_limit_out) else $error("sh");
	a_lr_edge: assert property (ctl[13] && ctl[11] && $rose(low_side_pwm_out) |=> !fault_out) else $error("lr");
	a_lf_edge: assert property (ctl[12] && ctl[10] && $fell(low_side_pwm_out) |=> !current_limit_out) else $error("lf");
	a_hf_edge: assert property (ctl[14] && ctl[10] && $fell(high_side_pwm_out) |=> !current_limit_out) else $error("hf");
	a_hr_edge: assert property (ctl[15] && ctl[11] && $rose(high_side_pwm_out) |=> !fault_out) else $error("hr");
endmodule
bind pleb_blanking pleb_blanking_props pleb_blanking_props_inst (.*);

// [sim/pleb_blanking_test.sv]
module pleb_blanking_test
	import pleb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, lv;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        high_side_pwm_out = 0, low_side_pwm_out = 0, fault_in = 1, current_limit_in = 1;
	logic        fault_out, current_limit_out;
	logic [15:0] blank_sources = '0;
	int          n_errors = 0, compares = 0, d = 3;
	pleb_blanking pleb_blanking_inst (.*);
	initial forever #5 pclk = ~pclk;
	task automatic close_out();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer; bounded wait on pready
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] dt);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge pclk);
		penable <= 1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			n_errors++;
			close_out();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic pw(int k, logic x);
		if (k < 2)
			high_side_pwm_out <= x;
		else
			low_side_pwm_out <= x;
	endtask
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (int a = 0; a < 16; a += 4)
		begin
			xfer(0, 12'(a), 0);
			chk("reset value", 0, rd);
		end
		xfer(1, PLEB_CONTROL_ADDR, 32'hFFFF_FFFF);
		xfer(0, PLEB_CONTROL_ADDR, 0);
		chk("control", 32'h0000_FC3F, rd);
		xfer(1, 12'h010, 32'h0000_1234);
		chk("unmapped err", 1, er);
		xfer(1, PLEB_CONTROL_ADDR, 0);
		xfer(1, PLEB_DELAY_ADDR, d);
		xfer(1, PLEB_AUX_ADDR, 3);
		xfer(0, PLEB_DELAY_ADDR, 0);
		chk("delay", d, rd);
		chk("pass high", 1, fault_out);
		fault_in <= 0;
		repeat (3) @(posedge pclk);
		chk("pass fault", 0, fault_out);
		fault_in <= 1;
		$display("test registers finished");
		// Each level enable, condition true and false
		for (int i = 0; i < 6; i++)
			for (int v = 0; v < 2; v++)
			begin
				xfer(1, PLEB_CONTROL_ADDR, 32'h1 << i);
				lv = v[0] ? i[0] : !i[0];
				case (i / 2)
					0: low_side_pwm_out <= lv;
					1: high_side_pwm_out <= lv;
					default: blank_sources <= lv ? 16'h0008 : 16'hFFF7;
				endcase
				repeat (3) @(posedge pclk);
				chk("state fault", !v[0], fault_out);
				chk("state limit", !v[0], current_limit_out);
			end
		$display("test state finished");
		// Each trigger edge; opposite edge must not blank
		for (int k = 0; k < 4; k++)
		begin
			pw(k, !k[0]);
			xfer(1, PLEB_CONTROL_ADDR, (32'h8000 >> k) | (k[0] ? 32'h0400 : 32'h0800));
			repeat (d + 3) @(posedge pclk);
			pw(k, k[0]);
			repeat (2) @(posedge pclk);
			chk("idle", 1, fault_out & current_limit_out);
			pw(k, !k[0]);
			repeat (d + 2) @(posedge pclk);
			chk("edge fault", k[0], fault_out);
			chk("edge limit", !k[0], current_limit_out);
			@(posedge pclk);
			chk("expired", 1, fault_out & current_limit_out);
		end
		$display("test edges finished");
		close_out();
	end
endmodule
